// file: design/cmc_map.vh
// register offsets, field positions and reset values of the comparator control block
`ifndef CMC_MAP_VH
`define CMC_MAP_VH

// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define CMC_OFS_CTRL 4'h0
`define CMC_OFS_STAT 4'h4
`define CMC_OFS_MASK 4'h8

// ----------------------------------------
// control register fields
// ----------------------------------------
`define CMC_BIT_ENABLE 15
`define CMC_BIT_DRIVE 14
`define CMC_BIT_INVERT 13
`define CMC_BIT_RESULT 8
`define CMC_EDGE_HI 7
`define CMC_EDGE_LO 6
`define CMC_BIT_POSSEL 4
`define CMC_NEG_HI 1
`define CMC_NEG_LO 0
`define CMC_CTRL_WMASK 32'h0000e0d3
`define CMC_CTRL_RESET 32'h000000c3

// ----------------------------------------
// edge select and negative input codes
// ----------------------------------------
`define CMC_EDGE_OFF 2'h0
`define CMC_EDGE_RISE 2'h1
`define CMC_EDGE_FALL 2'h2
`define CMC_EDGE_BOTH 2'h3
`define CMC_NEG_PIN_B 2'h0
`define CMC_NEG_PIN_C 2'h1
`define CMC_NEG_PIN_D 2'h2
`define CMC_NEG_REF 2'h3

// ----------------------------------------
// bus answers
// ----------------------------------------
`define CMC_RESP_OKAY 2'h0
`define CMC_RESP_SLVERR 2'h2

`endif

// file: design/cmc_sync.v
// two flip-flop synchroniser for a level from outside the clock domain
`timescale 1ns/1ps
module cmc_sync (
	clk,
	rst_b,
	asyncIn,
	syncOut
);
	input wire clk;
	input wire rst_b;
	input wire asyncIn; // raw level
	output reg syncOut; // level safe to read

	reg metaStage_reg; // first stage, read only by syncOut

	// ----------------------------------------
	// two-stage capture
	// ----------------------------------------
	always @(posedge clk) begin
		if (!rst_b) begin
			metaStage_reg <= 1'b0;
			syncOut <= 1'b0;
		end else begin
			metaStage_reg <= asyncIn;
			syncOut <= metaStage_reg;
		end
	end
endmodule

// file: design/cmc_edge.v
// edge detector on the polarity-corrected comparator result
`timescale 1ns/1ps
`include "cmc_map.vh"
module cmc_edge (
	clk,
	rst_b,
	levelIn,
	enable,
	edgeSelect,
	edgePulse
);
	input wire clk;
	input wire rst_b;
	input wire levelIn; // synchronised, polarity applied
	input wire enable; // module enabled
	input wire [1:0] edgeSelect; // which transitions count
	output reg edgePulse; // one-cycle event

	reg prevLevel_reg; // level one cycle ago
	wire rise; // low-to-high seen
	wire fall; // high-to-low seen

	assign rise = levelIn & ~prevLevel_reg;
	assign fall = ~levelIn & prevLevel_reg;

	// ----------------------------------------
	// qualify edges by the selected polarity
	// ----------------------------------------
	always @(posedge clk) begin
		if (!rst_b) begin
			prevLevel_reg <= 1'b0;
			edgePulse <= 1'b0;
		end else begin
			prevLevel_reg <= levelIn;
			case (edgeSelect)
				`CMC_EDGE_RISE: edgePulse <= enable & rise;
				`CMC_EDGE_FALL: edgePulse <= enable & fall;
				`CMC_EDGE_BOTH: edgePulse <= enable & (rise | fall);
				default: edgePulse <= 1'b0;
			endcase
		end
	end
endmodule

// file: design/cmc_comparator_control.v
// AXI4-Lite register block and control logic around one analog comparator
// Overview of operation
// - bit 15 enables comparator and gates edge events
// - bit 14 routes result to pin
// - bit 13 inverts the comparator result
// - inversion also feeds the interrupt edge detector
// - bit 8 shows live result, read-only
// - bits 7-6 pick interrupt edge or none
// - bit 4 picks reference or pin A
// - bits 1-0 pick negative input source
// - unimplemented control bits read zero
`timescale 1ns/1ps
`include "cmc_map.vh"
module cmc_comparator_control (
	clk,
	rst_b,
	s_axi_awaddr,
	s_axi_awvalid,
	s_axi_awready,
	s_axi_wdata,
	s_axi_wstrb,
	s_axi_wvalid,
	s_axi_wready,
	s_axi_bresp,
	s_axi_bvalid,
	s_axi_bready,
	s_axi_araddr,
	s_axi_arvalid,
	s_axi_arready,
	s_axi_rdata,
	s_axi_rresp,
	s_axi_rvalid,
	s_axi_rready,
	comparatorResult,
	comparatorEnable,
	positiveInputSelect,
	negativeInputSelect,
	resultOutputPin,
	resultOutputPinOe,
	edgeIrqPulse,
	irq
);
	parameter ADDR_WIDTH = 4;

	input wire clk;
	input wire rst_b;
	input wire [ADDR_WIDTH-1:0] s_axi_awaddr;
	input wire s_axi_awvalid;
	output reg s_axi_awready;
	input wire [31:0] s_axi_wdata;
	input wire [3:0] s_axi_wstrb;
	input wire s_axi_wvalid;
	output reg s_axi_wready;
	output reg [1:0] s_axi_bresp;
	output reg s_axi_bvalid;
	input wire s_axi_bready;
	input wire [ADDR_WIDTH-1:0] s_axi_araddr;
	input wire s_axi_arvalid;
	output reg s_axi_arready;
	output reg [31:0] s_axi_rdata;
	output reg [1:0] s_axi_rresp;
	output reg s_axi_rvalid;
	input wire s_axi_rready;
	input wire comparatorResult; // raw analog core output
	output reg comparatorEnable; // powers the analog core
	output reg positiveInputSelect; // 1 reference, 0 pin A
	output reg [1:0] negativeInputSelect; // negative mux code
	output reg resultOutputPin; // output pin level
	output reg resultOutputPinOe; // output pin drive enable
	output reg edgeIrqPulse; // one-cycle event request
	output reg irq; // level interrupt

	// ----------------------------------------
	// state
	// ----------------------------------------
	reg [31:0] ctrl_reg; // control register, implemented bits only
	reg eventStatus_reg; // sticky edge event
	reg eventMask_reg; // 1 lets the event reach irq
	reg eventStatus_next; // status value after this edge
	reg eventMask_next; // mask value after this edge
	reg awHeld_reg; // write address captured
	reg wHeld_reg; // write data captured
	reg [ADDR_WIDTH-1:0] awAddr_reg; // captured write address
	reg [31:0] wData_reg; // captured write data
	reg [3:0] wStrb_reg; // captured byte enables
	wire resultSync; // synchronised result
	wire polResult; // result after inversion
	wire edgeEvent; // qualified edge pulse
	wire doWrite; // both halves of a write present
	wire [31:0] wMerged; // strobe-merged write data
	wire wrCtrl; // write hits control
	wire wrStat; // write hits status
	wire wrMask; // write hits mask

	// merge new data under byte strobes
	function [31:0] strobeMerge;
		input [31:0] oldVal;
		input [31:0] newVal;
		input [3:0] strb;
		integer i;
		begin
			strobeMerge = oldVal;
			for (i = 0; i < 4; i = i + 1) begin
				if (strb[i]) begin
					strobeMerge[i*8 +: 8] = newVal[i*8 +: 8];
				end
			end
		end
	endfunction

	// word-aligned address compare
	function addrHit;
		input [ADDR_WIDTH-1:0] addr;
		input [3:0] ofs;
		begin
			addrHit = (addr[3:2] == ofs[3:2]);
		end
	endfunction

	// is the address one of the three registers
	function addrMapped;
		input [ADDR_WIDTH-1:0] addr;
		begin
			addrMapped = addrHit(addr, `CMC_OFS_CTRL) | addrHit(addr, `CMC_OFS_STAT) |
				addrHit(addr, `CMC_OFS_MASK);
		end
	endfunction

	// ----------------------------------------
	// result path
	// ----------------------------------------
	// two-flop synchroniser
	cmc_sync resultSyncer (
		.clk(clk),
		.rst_b(rst_b),
		.asyncIn(comparatorResult),
		.syncOut(resultSync)
	);

	assign polResult = resultSync ^ ctrl_reg[`CMC_BIT_INVERT];

	cmc_edge edgeDetect (
		.clk(clk),
		.rst_b(rst_b),
		.levelIn(polResult),
		.enable(ctrl_reg[`CMC_BIT_ENABLE]),
		.edgeSelect(ctrl_reg[`CMC_EDGE_HI:`CMC_EDGE_LO]),
		.edgePulse(edgeEvent)
	);

	// ----------------------------------------
	// write decode
	// ----------------------------------------
	assign doWrite = awHeld_reg & wHeld_reg & ~s_axi_bvalid;
	assign wMerged = strobeMerge(ctrl_reg, wData_reg, wStrb_reg);
	assign wrCtrl = doWrite & addrHit(awAddr_reg, `CMC_OFS_CTRL);
	assign wrStat = doWrite & addrHit(awAddr_reg, `CMC_OFS_STAT) & wStrb_reg[0];
	assign wrMask = doWrite & addrHit(awAddr_reg, `CMC_OFS_MASK) & wStrb_reg[0];

	// ----------------------------------------
	// write channels, address and data in either order
	// ----------------------------------------
	always @(posedge clk) begin
		if (!rst_b) begin
			awHeld_reg <= 1'b0;
			wHeld_reg <= 1'b0;
			awAddr_reg <= {ADDR_WIDTH{1'b0}};
			wData_reg <= 32'h00000000;
			wStrb_reg <= 4'h0;
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= `CMC_RESP_OKAY;
		end else begin
			// ready offered one cycle while slot empty
			s_axi_awready <= ~awHeld_reg & ~s_axi_awready & ~s_axi_bvalid;
			s_axi_wready <= ~wHeld_reg & ~s_axi_wready & ~s_axi_bvalid;
			if (s_axi_awvalid & s_axi_awready) begin
				awHeld_reg <= 1'b1;
				awAddr_reg <= s_axi_awaddr;
			end
			if (s_axi_wvalid & s_axi_wready) begin
				wHeld_reg <= 1'b1;
				wData_reg <= s_axi_wdata;
				wStrb_reg <= s_axi_wstrb;
			end
			// response after both halves
			if (doWrite) begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= addrMapped(awAddr_reg) ? `CMC_RESP_OKAY : `CMC_RESP_SLVERR;
				awHeld_reg <= 1'b0;
				wHeld_reg <= 1'b0;
			end else if (s_axi_bvalid & s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	// ----------------------------------------
	// event status and mask next values
	// ----------------------------------------
	// sticky event, set wins over a same-cycle clear
	always @* begin
		eventStatus_next = eventStatus_reg;
		eventMask_next = eventMask_reg;
		// a new edge outranks the software clear
		if (edgeEvent) begin
			eventStatus_next = 1'b1;
		end else if (wrStat & wData_reg[0]) begin
			// write one to clear
			eventStatus_next = 1'b0;
		end
		// mask bit follows a write to its word
		if (wrMask) begin
			eventMask_next = wData_reg[0];
		end
	end

	// ----------------------------------------
	// registers
	// ----------------------------------------
	always @(posedge clk) begin
		if (!rst_b) begin
			ctrl_reg <= `CMC_CTRL_RESET;
			eventStatus_reg <= 1'b0;
			eventMask_reg <= 1'b0;
		end else begin
			if (wrCtrl) begin
				ctrl_reg <= wMerged & `CMC_CTRL_WMASK;
			end
			// status and mask take their prepared next values
			eventStatus_reg <= eventStatus_next;
			eventMask_reg <= eventMask_next;
		end
	end

	// ----------------------------------------
	// read channel
	// ----------------------------------------
	always @(posedge clk) begin
		if (!rst_b) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h00000000;
			s_axi_rresp <= `CMC_RESP_OKAY;
		end else begin
			s_axi_arready <= ~s_axi_arready & ~s_axi_rvalid;
			if (s_axi_arvalid & s_axi_arready) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rresp <= `CMC_RESP_OKAY;
				s_axi_rdata <= 32'h00000000;
				if (addrHit(s_axi_araddr, `CMC_OFS_CTRL)) begin
					s_axi_rdata <= ctrl_reg | ({31'h00000000, polResult} << `CMC_BIT_RESULT);
				end else if (addrHit(s_axi_araddr, `CMC_OFS_STAT)) begin
					s_axi_rdata <= {31'h00000000, eventStatus_reg};
				end else if (addrHit(s_axi_araddr, `CMC_OFS_MASK)) begin
					s_axi_rdata <= {31'h00000000, eventMask_reg};
				end else begin
					s_axi_rresp <= `CMC_RESP_SLVERR;
				end
			end else if (s_axi_rvalid & s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end

	// ----------------------------------------
	// analog control, pin and interrupt outputs
	// ----------------------------------------
	always @(posedge clk) begin
		if (!rst_b) begin
			comparatorEnable <= 1'b0;
			positiveInputSelect <= 1'b0;
			negativeInputSelect <= `CMC_NEG_REF;
			resultOutputPin <= 1'b0;
			resultOutputPinOe <= 1'b0;
			edgeIrqPulse <= 1'b0;
			irq <= 1'b0;
		end else begin
			comparatorEnable <= ctrl_reg[`CMC_BIT_ENABLE];
			positiveInputSelect <= ctrl_reg[`CMC_BIT_POSSEL];
			negativeInputSelect <= ctrl_reg[`CMC_NEG_HI:`CMC_NEG_LO];
			resultOutputPinOe <= ctrl_reg[`CMC_BIT_DRIVE];
			resultOutputPin <= ctrl_reg[`CMC_BIT_DRIVE] & polResult;
			edgeIrqPulse <= edgeEvent;
			// level follows unmasked status on the same edge, no lag on clear
			irq <= eventStatus_next & eventMask_next;
		end
	end
endmodule

// file: bench/cmc_comparator_control_assertions.sv
// concurrent checks on the comparator control block ports
`timescale 1ns/1ps
module cmc_checker (
	input logic clk,
	input logic rst_b,
	input logic s_axi_bvalid,
	input logic s_axi_rvalid,
	input logic [31:0] s_axi_rdata,
	input logic comparatorEnable,
	input logic positiveInputSelect,
	input logic [1:0] negativeInputSelect,
	input logic resultOutputPin,
	input logic resultOutputPinOe,
	input logic edgeIrqPulse,
	input logic irq
);
	// ----------------------------------------
	// reset values, settings moving only around a write answer, pin and event gating, unimplemented bits reading zero
	// ----------------------------------------
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_b);
	reset_vals_a: assert property (disable iff (1'b0) !rst_b |=> !comparatorEnable && negativeInputSelect == 2'h3 && !irq)
		else $error("reset values wrong");
	en_write_a: assert property ($changed(comparatorEnable) |-> s_axi_bvalid || $past(s_axi_bvalid))
		else $error("enable moved without a write");
	pos_write_a: assert property ($changed(positiveInputSelect) |-> s_axi_bvalid || $past(s_axi_bvalid))
		else $error("positive select moved without a write");
	neg_write_a: assert property ($changed(negativeInputSelect) |-> s_axi_bvalid || $past(s_axi_bvalid))
		else $error("negative select moved without a write");
	oe_write_a: assert property ($changed(resultOutputPinOe) |-> s_axi_bvalid || $past(s_axi_bvalid))
		else $error("pin drive moved without a write");
	pin_gate_a: assert property (!resultOutputPinOe |-> !resultOutputPin)
		else $error("pin driven while drive off");
	pulse_en_a: assert property (edgeIrqPulse |-> comparatorEnable || $past(comparatorEnable) || $past(comparatorEnable, 2))
		else $error("event while disabled");
	read_zero_a: assert property (s_axi_rvalid |-> (s_axi_rdata & 32'hffff1e2c) == 32'h0)
		else $error("unimplemented bits read nonzero");
endmodule
bind cmc_comparator_control cmc_checker chk_u (.clk, .rst_b, .s_axi_bvalid, .s_axi_rvalid, .s_axi_rdata,
	.comparatorEnable, .positiveInputSelect, .negativeInputSelect, .resultOutputPin, .resultOutputPinOe,
	.edgeIrqPulse, .irq);

// file: bench/cmc_analog_model.sv
// behavioural analog comparator core with its input multiplexers
`timescale 1ns/1ps
module cmc_analog_model (
	input logic posSel,
	input logic [1:0] negSel,
	input logic [19:0] levels, // nibbles: D C B A reference
	output logic result
);
	logic [3:0] posLvl; // chosen non-inverting level
	logic [3:0] negLvl; // chosen inverting level
	// keeps comparing while powered down, so the block's own gating is exercised
	always_comb begin
		posLvl = posSel ? levels[3:0] : levels[7:4];
		case (negSel)
			2'h0: negLvl = levels[11:8];
			2'h1: negLvl = levels[15:12];
			2'h2: negLvl = levels[19:16];
			default: negLvl = levels[3:0];
		endcase
		result = posLvl > negLvl;
	end
endmodule

// file: bench/tb_top.sv
// self-checking bench for the comparator control block
`timescale 1ns/1ps
module tb_top;
	logic clk = 0, rst_b = 0;
	logic [3:0] s_axi_awaddr = 0, s_axi_araddr = 0, s_axi_wstrb = 0;
	logic [31:0] s_axi_wdata = 0, s_axi_rdata, rd;
	logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0] s_axi_bresp, s_axi_rresp, rsp, negativeInputSelect;
	logic comparatorResult, comparatorEnable, positiveInputSelect, resultOutputPin, resultOutputPinOe, edgeIrqPulse, irq;
	logic [19:0] levels = 0; // analog source levels
	int num_errors = 0, n_compared = 0, i;
	int pulseCount = 0; // event pulses seen on the edge output
	cmc_comparator_control dut_u (.clk, .rst_b, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
		.s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
		.s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .comparatorResult,
		.comparatorEnable, .positiveInputSelect, .negativeInputSelect, .resultOutputPin, .resultOutputPinOe,
		.edgeIrqPulse, .irq);
	cmc_analog_model core_u (.posSel(positiveInputSelect), .negSel(negativeInputSelect), .levels(levels),
		.result(comparatorResult));
	initial forever #5 clk = ~clk;
	// count one-cycle event pulses
	always @(posedge clk) begin
		if (edgeIrqPulse === 1'b1) pulseCount <= pulseCount + 1;
	end
	// compare and count
	task chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			num_errors++;
			$display("ERROR %s expected %h seen %h", nm, exp, got);
		end
	endtask
	// one bus cycle; readies sampled at the falling edge before the taking edge
	// no cycle count assumed: a wait ends when the response is seen, or by the watchdog if none comes
	task bus(input bit w, input logic [3:0] a, input logic [31:0] d);
		bit g, h, b;
		@(posedge clk);
		if (w) begin
			{s_axi_awaddr, s_axi_wdata, s_axi_wstrb} <= {a, d, 4'hf};
			{s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
		end else begin
			s_axi_araddr <= a;
			{s_axi_arvalid, s_axi_rready} <= 2'h3;
		end
		forever begin
			@(negedge clk);
			g = w ? s_axi_awready : s_axi_arready;
			h = s_axi_wready;
			b = w ? s_axi_bvalid : s_axi_rvalid;
			rsp = w ? s_axi_bresp : s_axi_rresp;
			rd = s_axi_rdata;
			@(posedge clk);
			if (g && w) s_axi_awvalid <= 0;
			if (g && !w) s_axi_arvalid <= 0;
			if (h && w) s_axi_wvalid <= 0;
			if (b) begin
				{s_axi_bready, s_axi_rready} <= 2'h0;
				break;
			end
		end
	endtask
	// settle, read, compare, end off the rising edge
	task rdchk(input string nm, input logic [3:0] a, input logic [31:0] e);
		repeat (4) @(posedge clk);
		bus(0, a, 0);
		chk(nm, rd, e);
		@(negedge clk);
	endtask
	task conclude;
		if (num_errors == 0 && n_compared > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask
	initial begin
		#200000;
		num_errors++;
		conclude;
	end
	initial begin
		repeat (4) @(posedge clk);
		rst_b <= 1;
		rdchk("ctrl", 0, 32'hc3);
		chk("outs", {comparatorEnable, positiveInputSelect, negativeInputSelect, resultOutputPinOe, resultOutputPin}, 6'h0c);
		bus(1, 0, 32'hffffffff);
		chk("wresp", rsp, 0);
		rdchk("ctrl", 0, 32'he1d3);
		chk("outs", {comparatorEnable, positiveInputSelect, negativeInputSelect, resultOutputPinOe, resultOutputPin}, 6'h3f);
		levels <= 20'h46450;
		for (i = 0; i < 4; i++) begin
			bus(1, 0, 32'h8000 | i);
			rdchk("negsel", 0, 32'h8000 | i | (((32'hd >> i) & 1) << 8));
			chk("negpin", negativeInputSelect, i);
		end
		bus(1, 8, 1);
		for (i = 0; i < 4; i++) begin
			levels <= 20'h00400;
			bus(1, 0, 32'h8000 | i << 6);
			bus(1, 4, 1);
			levels <= 20'h00450;
			rdchk("rise", 4, i & 1);
			chk("irq", irq, i & 1);
			bus(1, 4, 1);
			levels <= 20'h00400;
			rdchk("fall", 4, i >> 1);
		end
		bus(1, 0, 32'ha040);
		bus(1, 4, 1);
		levels <= 20'h00450;
		rdchk("inv", 4, 0);
		levels <= 20'h00400;
		rdchk("inv", 4, 1);
		bus(1, 8, 0);
		rdchk("held", 4, 1);
		chk("masked", irq, 0);
		bus(1, 0, 32'h20c0);
		bus(1, 4, 1);
		levels <= 20'h00450;
		rdchk("off", 4, 0);
		bus(1, 4'hc, 32'hffffffff);
		chk("wresp", rsp, 2);
		rdchk("ctrl", 0, 32'h20c0);
		rdchk("unmapped", 4'hc, 0);
		chk("resp", rsp, 2);
		chk("pulses", pulseCount, 7);
		conclude;
	end
endmodule
